// [design/crsq_pkg.sv]
// ----------------------------------------------------------------------------
// Shared constants of the cipher register bank and buffer sequencer.
// ----------------------------------------------------------------------------
package crsq_pkg;

	// Widths of the register port and of the cipher data paths.
	localparam int ADDR_W    = 16;
	localparam int DATA_W    = 32;
	localparam int BLOCK_W   = 128;
	localparam int KEY_WORDS = 8;

	// Area codes carried in address bits [15:11].
	localparam logic [4:0] AREA_PLAIN  = 5'h01;
	localparam logic [4:0] AREA_CIPHER = 5'h02;

	// Internal register offsets, matched against address bits [10:0].
	localparam logic [10:0] OFS_PLAIN_PTR  = 11'h000;
	localparam logic [10:0] OFS_CIPHER_PTR = 11'h004;
	localparam logic [10:0] OFS_ENC_CNT    = 11'h008;
	localparam logic [10:0] OFS_DEC_CNT    = 11'h00c;
	localparam logic [10:0] OFS_ENC_KEY    = 11'h020;
	localparam logic [10:0] OFS_DEC_KEY    = 11'h040;

	// Clock cycles that a key expansion takes after its load pulse.
	localparam logic [31:0] KEY_SETUP_CYCLES = 32'h0000000e;

	// Values after reset.
	localparam logic [31:0] CNT_RST  = 32'h00000000;
	localparam logic [31:0] WORD_RST = 32'h00000000;

endpackage : crsq_pkg

// [design/crsq_ram_if.sv]
// ----------------------------------------------------------------------------
// Link between the sequencer and one buffer RAM.
// ----------------------------------------------------------------------------
interface crsq_ram_if #(
	parameter int BLOCK_W = 128,
	parameter int PTR_W   = 7,
	parameter int WADDR_W = 9
);
	logic               b_we;        // Register-side word write.
	logic [WADDR_W-1:0] b_waddr;     // Register-side write word address.
	logic [3:0]         b_lanes;     // Byte lanes of the write.
	logic [31:0]        b_wdata;     // Register-side write word.
	logic [WADDR_W-1:0] b_raddr;     // Register-side read word address.
	logic [31:0]        b_rdata;     // Register-side read word.
	logic [PTR_W-1:0]   a_ptr;       // Port-A block pointer.
	logic               a_rd;        // Port-A block read strobe.
	logic [BLOCK_W-1:0] a_rdata;     // Port-A block read one cycle later.
	logic               a_wr_done;   // A buffered block is written at a_ptr.
	logic               fill_valid;  // Cipher core offers a result block.
	logic [BLOCK_W-1:0] fill_data;   // The offered result block.
	logic               fill_ready;  // Write buffer can take a block.

	modport ctrl (
		output b_we, b_waddr, b_lanes, b_wdata, b_raddr, a_ptr, a_rd,
		output fill_valid, fill_data,
		input  b_rdata, a_rdata, a_wr_done, fill_ready
	);
	modport ram (
		input  b_we, b_waddr, b_lanes, b_wdata, b_raddr, a_ptr, a_rd,
		input  fill_valid, fill_data,
		output b_rdata, a_rdata, a_wr_done, fill_ready
	);
endinterface : crsq_ram_if

// [design/crsq_buf_ram.sv]
// ----------------------------------------------------------------------------
// Buffer RAM: 32-bit register port B, 128-bit block port A with a small
// write buffer that drains only while port A is not reading.
// ----------------------------------------------------------------------------
module crsq_buf_ram #(
	parameter int BLOCK_W    = 128,
	parameter int DEPTH      = 128,
	parameter int FIFO_DEPTH = 2
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Link to the sequencer.
	crsq_ram_if.ram  ifc
);
	localparam int LANES = BLOCK_W / 32;
	localparam int LW    = $clog2(LANES);
	localparam int IW    = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW    = $clog2(FIFO_DEPTH + 1);
	localparam logic [IW-1:0] LAST_IDX = IW'(FIFO_DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

	logic [BLOCK_W-1:0] mem_r  [DEPTH];      // Block storage.
	logic [BLOCK_W-1:0] fifo_r [FIFO_DEPTH]; // Write buffer entries.
	logic [IW-1:0]      wr_idx_r;            // Next entry to fill.
	logic [IW-1:0]      rd_idx_r;            // Oldest entry.
	logic [CW-1:0]      cnt_r;               // Entries held.
	logic [CW-1:0]      cnt_nxt;             // Entries held next cycle.
	logic               ready_r;             // Registered fill ready.
	logic [BLOCK_W-1:0] a_rdata_r;           // Port-A read register.
	logic               push;                // A block enters the buffer.
	logic               pop;                 // A block leaves for the RAM.

	// ------------------------------------------------------------------------
	// Write buffer control.
	// ------------------------------------------------------------------------
	// Draining stalls while the sequencer reads port A, so the buffer can fill.
	assign push = ifc.fill_valid && ready_r;
	assign pop  = (cnt_r != '0) && !ifc.a_rd;
	assign ifc.a_wr_done  = pop;
	assign ifc.fill_ready = ready_r;
	assign ifc.a_rdata    = a_rdata_r;

	// Occupancy after this cycle's push and pop.
	always_comb begin
		cnt_nxt = cnt_r;
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Indices, count and ready all restart empty.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			cnt_r    <= '0;
			ready_r  <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			ready_r <= (cnt_nxt < FULL_CNT);
			if (push) begin
				wr_idx_r <= (wr_idx_r == LAST_IDX) ? '0 : wr_idx_r + 1'b1;
			end
			if (pop) begin
				rd_idx_r <= (rd_idx_r == LAST_IDX) ? '0 : rd_idx_r + 1'b1;
			end
		end
	end

	// Buffer entries hold data only and need no reset.
	always_ff @(posedge clk) begin
		if (push) begin
			fifo_r[wr_idx_r] <= ifc.fill_data;
		end
	end

	// ------------------------------------------------------------------------
	// Storage.
	// ------------------------------------------------------------------------
	// Byte lanes gate port-B writes; a port-A block write lands afterwards.
	always_ff @(posedge clk) begin
		if (ifc.b_we) begin
			for (int k = 0; k < 4; k++) begin
				if (ifc.b_lanes[k]) begin
					mem_r[ifc.b_waddr[$bits(ifc.b_waddr)-1:LW]]
						[{ifc.b_waddr[LW-1:0], 5'h00} + 8*k +: 8] <= ifc.b_wdata[8*k +: 8];
				end
			end
		end
		if (pop) begin
			mem_r[ifc.a_ptr] <= fifo_r[rd_idx_r];
		end
	end

	// Port-A block read, one cycle after the strobe.
	always_ff @(posedge clk) begin
		if (ifc.a_rd) begin
			a_rdata_r <= mem_r[ifc.a_ptr];
		end
	end

	// Port-B word read, registered by the sequencer.
	assign ifc.b_rdata = mem_r[ifc.b_raddr[$bits(ifc.b_raddr)-1:LW]]
		[{ifc.b_raddr[LW-1:0], 5'h00} +: 32];

endmodule : crsq_buf_ram

// [design/crsq_top.sv]
module crsq_top
	import crsq_pkg::*;
#(
	parameter int DEPTH      = 128,
	parameter int FIFO_DEPTH = 2
) (
	// Clock and reset.
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// Register port.
	input  wire logic                reg_write_strobe,
	input  wire logic [ADDR_W-1:0]   reg_addr_bus,
	input  wire logic [DATA_W-1:0]   reg_write_value,
	input  wire logic [3:0]          reg_byte_lanes,
	input  wire logic                reg_read_request,
	output logic                     read_value_valid,
	output logic [DATA_W-1:0]        reg_read_value,
	// Encryptor side.
	output logic [KEY_WORDS*32-1:0]  encrypt_key_value,
	output logic                     encrypt_key_load,
	output logic [BLOCK_W-1:0]       encrypt_input_block,
	output logic                     encrypt_input_valid,
	input  wire logic [BLOCK_W-1:0]  encrypt_output_block,
	input  wire logic                encrypt_output_valid,
	output logic                     encrypt_output_ready,
	// Decryptor side.
	output logic [KEY_WORDS*32-1:0]  decrypt_key_value,
	output logic                     decrypt_key_load,
	output logic [BLOCK_W-1:0]       decrypt_input_block,
	output logic                     decrypt_input_valid,
	input  wire logic [BLOCK_W-1:0]  decrypt_output_block,
	input  wire logic                decrypt_output_valid,
	output logic                     decrypt_output_ready
);
	// ------------------------------------------------------------------------
	// Declarations. Index 0 is the encrypt channel and plain buffer, index 1
	// the decrypt channel and cipher buffer. Channel c reads buffer c and
	// writes its results into buffer 1-c.
	// ------------------------------------------------------------------------
	localparam int PTR_W   = $clog2(DEPTH);
	localparam int WADDR_W = $clog2(DEPTH * BLOCK_W / 32);
	localparam logic [10:0] PTR_OFS [2] = '{OFS_PLAIN_PTR, OFS_CIPHER_PTR};
	localparam logic [10:0] CNT_OFS [2] = '{OFS_ENC_CNT, OFS_DEC_CNT};
	localparam logic [10:0] KEY_OFS [2] = '{OFS_ENC_KEY, OFS_DEC_KEY};

	logic [KEY_WORDS-1:0][31:0] key_r [2];   // Key words, word 0 lowest.
	logic                       load_r [2];  // Key load pulses.
	logic [31:0]                cnt_r [2];   // Blocks left or setup cycles.
	logic                       busy_r [2];  // Key setup in progress.
	logic                       rd_r [2];    // Block read strobes.
	logic                       ivld_r [2];  // Core input valid.
	logic [PTR_W-1:0]           ptr_r [2];   // Port-A pointers per buffer.
	logic                       ovld [2];    // Core result valid.
	logic [BLOCK_W-1:0]         oblk [2];    // Core result block.
	logic [4:0]                 area;        // Area code of the request.
	logic [10:0]                ofs;         // Register offset of the request.
	logic                       wr_int;      // Write to the internal registers.
	logic                       read_request_q; // Registered read request.
	logic [ADDR_W-1:0]          raddr_q;     // Registered read address.
	logic [DATA_W-1:0]          rd_mux;      // Selected read word.

	crsq_ram_if #(.BLOCK_W(BLOCK_W), .PTR_W(PTR_W), .WADDR_W(WADDR_W)) ram_if [2] ();

	// All assertions below sample on the one clock and rest during reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ------------------------------------------------------------------------
	// Write decode.
	// ------------------------------------------------------------------------
	// The area code picks a buffer; anything else is a register write.
	assign area   = reg_addr_bus[15:11];
	assign ofs    = reg_addr_bus[10:0];
	assign wr_int = reg_write_strobe && (area != AREA_PLAIN) && (area != AREA_CIPHER);

	assign ovld[0] = encrypt_output_valid;
	assign oblk[0] = encrypt_output_block;
	assign ovld[1] = decrypt_output_valid;
	assign oblk[1] = decrypt_output_block;

	// ------------------------------------------------------------------------
	// Per-channel sequencing and per-buffer wiring.
	// ------------------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_ch
		localparam logic [4:0] MY_AREA = (g == 0) ? AREA_PLAIN : AREA_CIPHER;
		logic [31:0] cnt_nxt;  // Count for the next cycle.
		logic        busy_nxt; // Setup flag for the next cycle.
		logic        key_wr;   // Write into this channel's key words.
		logic        key_low;  // Write of the lowest key word.
		logic        cnt_wr;   // Write of this channel's count.
		logic        ptr_wr;   // Write of this buffer's pointer.
		logic [4:0]  age_r;    // Checker helper: cycles since the key load.

		assign key_wr  = wr_int && (ofs[10:5] == KEY_OFS[g][10:5]);
		assign key_low = wr_int && (ofs == KEY_OFS[g]);
		assign cnt_wr  = wr_int && (ofs == CNT_OFS[g]);
		assign ptr_wr  = wr_int && (ofs == PTR_OFS[g]);

		// Buffer g takes register writes in its own area.
		assign ram_if[g].b_we       = reg_write_strobe && (area == MY_AREA);
		assign ram_if[g].b_waddr    = reg_addr_bus[WADDR_W+1:2];
		assign ram_if[g].b_lanes    = reg_byte_lanes;
		assign ram_if[g].b_wdata    = reg_write_value;
		assign ram_if[g].b_raddr    = raddr_q[WADDR_W+1:2];
		assign ram_if[g].a_ptr      = ptr_r[g];
		assign ram_if[g].a_rd       = rd_r[g];
		// Results of the other channel fill this buffer.
		assign ram_if[g].fill_valid = ovld[1-g];
		assign ram_if[g].fill_data  = oblk[1-g];

		crsq_buf_ram #(
			.BLOCK_W    (BLOCK_W),
			.DEPTH      (DEPTH),
			.FIFO_DEPTH (FIFO_DEPTH)
		) u_ram (
			.clk     (clk),
			.sys_rst (sys_rst),
			.ifc     (ram_if[g])
		);

		// Next count: a low key word write arms the setup timer, a count write loads
		// blocks, and each read or setup cycle takes one off.
		always_comb begin
			cnt_nxt  = cnt_r[g];
			busy_nxt = busy_r[g];
			if (key_low) begin
				cnt_nxt  = KEY_SETUP_CYCLES;
				busy_nxt = 1'b1;
			end else if (cnt_wr) begin
				cnt_nxt = reg_write_value;
			end else if ((rd_r[g] || busy_r[g]) && (cnt_r[g] != CNT_RST)) begin
				cnt_nxt = cnt_r[g] - 32'h00000001;
			end
			if (cnt_nxt == CNT_RST) begin
				busy_nxt = 1'b0;
			end
		end

		// Count, setup flag and strobe; no block is read during key setup.
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				cnt_r[g]  <= CNT_RST;
				busy_r[g] <= 1'b0;
				rd_r[g]   <= 1'b0;
				ivld_r[g] <= 1'b0;
			end else begin
				cnt_r[g]  <= cnt_nxt;
				busy_r[g] <= busy_nxt;
				rd_r[g]   <= !busy_nxt && (cnt_nxt != CNT_RST);
				ivld_r[g] <= rd_r[g];
			end
		end

		// Pointer: software load wins, else steps on a read or a result write.
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				ptr_r[g] <= '0;
			end else if (ptr_wr) begin
				ptr_r[g] <= reg_write_value[PTR_W-1:0];
			end else if (rd_r[g] || ram_if[g].a_wr_done) begin
				ptr_r[g] <= ptr_r[g] + 1'b1;
			end
		end

		// Key words and the load pulse one cycle after the low word lands.
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				key_r[g]  <= '0;
				load_r[g] <= 1'b0;
			end else begin
				load_r[g] <= key_low;
				if (key_wr) begin
					key_r[g][ofs[4:2]] <= reg_write_value;
				end
			end
		end

		// Checker helper: counts cycles after a low key word write and
		// saturates. A count write overrides the setup countdown, so it
		// parks the counter where no setup assertion looks.
		always_ff @(posedge clk) begin
			if (sys_rst || cnt_wr) begin
				age_r <= 5'h1f;
			end else if (key_low) begin
				age_r <= 5'h00;
			end else if (age_r != 5'h1f) begin
				age_r <= age_r + 5'h01;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Core-facing outputs.
	// ------------------------------------------------------------------------
	assign encrypt_key_value    = key_r[0];
	assign encrypt_key_load     = load_r[0];
	assign encrypt_input_block  = ram_if[0].a_rdata;
	assign encrypt_input_valid  = ivld_r[0];
	assign encrypt_output_ready = ram_if[1].fill_ready;
	assign decrypt_key_value    = key_r[1];
	assign decrypt_key_load     = load_r[1];
	assign decrypt_input_block  = ram_if[1].a_rdata;
	assign decrypt_input_valid  = ivld_r[1];
	assign decrypt_output_ready = ram_if[0].fill_ready;

	// ------------------------------------------------------------------------
	// Read path.
	// ------------------------------------------------------------------------
	// The area first, then the word within it.
	always_comb begin
		rd_mux = WORD_RST;
		if (raddr_q[15:11] == AREA_PLAIN) begin
			rd_mux = ram_if[0].b_rdata;
		end else if (raddr_q[15:11] == AREA_CIPHER) begin
			rd_mux = ram_if[1].b_rdata;
		end else if (raddr_q[10:5] == OFS_ENC_KEY[10:5]) begin
			rd_mux = key_r[0][raddr_q[4:2]];
		end else if (raddr_q[10:5] == OFS_DEC_KEY[10:5]) begin
			rd_mux = key_r[1][raddr_q[4:2]];
		end else begin
			unique case (raddr_q[10:0])
				OFS_PLAIN_PTR:  rd_mux = {{(32-PTR_W){1'b0}}, ptr_r[0]};
				OFS_CIPHER_PTR: rd_mux = {{(32-PTR_W){1'b0}}, ptr_r[1]};
				OFS_ENC_CNT:    rd_mux = cnt_r[0];
				OFS_DEC_CNT:    rd_mux = cnt_r[1];
				default:        rd_mux = WORD_RST;
			endcase
		end
	end

	// Request is registered first; valid and data follow one cycle later.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			read_request_q   <= 1'b0;
			raddr_q          <= '0;
			read_value_valid <= 1'b0;
			reg_read_value   <= WORD_RST;
		end else begin
			read_request_q   <= reg_read_request;
			raddr_q          <= reg_addr_bus;
			read_value_valid <= read_request_q;
			if (read_request_q) begin
				reg_read_value <= rd_mux;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Assertions and covers.
	// ------------------------------------------------------------------------
	AST_READ_TWO_CYCLES: assert property (
		reg_read_request |-> ##2 read_value_valid)
		else $error("read data not valid two cycles after request");
	AST_ENC_KEY_LOAD: assert property (
		(reg_write_strobe && reg_addr_bus == {5'h00, OFS_ENC_KEY}) |=> encrypt_key_load)
		else $error("encrypt key load missing after low word write");
	AST_DEC_KEY_LOAD: assert property (
		(reg_write_strobe && reg_addr_bus == {5'h00, OFS_DEC_KEY}) |=> decrypt_key_load)
		else $error("decrypt key load missing after low word write");
	AST_ENC_KEY_DONE: assert property (
		(32'(g_ch[0].age_r) == KEY_SETUP_CYCLES) |-> (cnt_r[0] == CNT_RST)
		&& !busy_r[0] && $past(busy_r[0]) && ($past(cnt_r[0]) == 32'h00000001))
		else $error("encrypt key setup did not end after fourteen cycles");
	AST_DEC_KEY_DONE: assert property (
		(32'(g_ch[1].age_r) == KEY_SETUP_CYCLES) |-> (cnt_r[1] == CNT_RST)
		&& !busy_r[1] && $past(busy_r[1]) && ($past(cnt_r[1]) == 32'h00000001))
		else $error("decrypt key setup did not end after fourteen cycles");
	AST_ENC_STROBE_COUNT: assert property (
		rd_r[0] |-> (cnt_r[0] != CNT_RST) && !busy_r[0])
		else $error("plain read strobe with zero count or during setup");
	AST_DEC_STROBE_COUNT: assert property (
		rd_r[1] |-> (cnt_r[1] != CNT_RST) && !busy_r[1])
		else $error("cipher read strobe with zero count or during setup");
	AST_ENC_VALID_DELAY: assert property (
		rd_r[0] |=> encrypt_input_valid)
		else $error("encrypt input valid not one cycle after strobe");
	AST_DEC_VALID_DELAY: assert property (
		rd_r[1] |=> decrypt_input_valid)
		else $error("decrypt input valid not one cycle after strobe");
	AST_PLAIN_PTR_STEP: assert property (
		(rd_r[0] && !(wr_int && ofs == OFS_PLAIN_PTR))
		|=> ptr_r[0] == $past(ptr_r[0]) + 1'b1)
		else $error("plain pointer did not step on a block read");
	AST_ENC_COUNT_STEP: assert property (
		(rd_r[0] && !reg_write_strobe) |=> cnt_r[0] == $past(cnt_r[0]) - 32'h00000001)
		else $error("encrypt count did not drop on a block read");

	COV_ENC_RUN: cover property (rd_r[0] ##1 rd_r[0] ##1 !rd_r[0]);
	COV_DEC_RUN: cover property (rd_r[1] ##1 rd_r[1] ##1 !rd_r[1]);
	COV_KEY_SETUP: cover property (encrypt_key_load ##14 !busy_r[0]);
	COV_BUF_FULL: cover property (encrypt_output_valid && !encrypt_output_ready);

endmodule : crsq_top

// [test/crsq_core_model.sv]
// ----------------------------------------------------------------------------
// Behavioural cipher core: each result is the block xor the low key half.
// ----------------------------------------------------------------------------
module crsq_core_model
	import crsq_pkg::*;
(
	// Clock and reset.
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// Key and blocks from the sequencer.
	input  wire logic [BLOCK_W-1:0] key_low,
	input  wire logic               in_valid,
	input  wire logic [BLOCK_W-1:0] in_block,
	// Results back to the sequencer.
	output logic                    out_valid,
	output logic [BLOCK_W-1:0]      out_block,
	input  wire logic               out_ready,
	// Bench stall control and drained flag.
	input  wire logic               hold_off,
	output logic                    idle
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [BLOCK_W-1:0] pend[$]; // Results not yet taken by the sequencer.

	// Offers the oldest result and keeps it up, unchanged, until it is taken.
	always @(posedge clk) begin
		if (sys_rst) begin
			pend.delete();
			out_valid <= 1'b0;
			out_block <= '0;
			idle      <= 1'b1;
		end else begin
			if (out_valid && out_ready) begin
				void'(pend.pop_front());
			end
			if (in_valid) begin
				pend.push_back(in_block ^ key_low);
			end
			if (out_valid && !out_ready) begin
				// An offered result is never withdrawn.
			end else if (pend.size() != 0 && !hold_off) begin
				out_valid <= 1'b1;
				out_block <= pend[0];
			end else begin
				// Nothing offered: the lines alternate between the last block and its inverse.
				out_valid <= 1'b0;
				out_block <= ~out_block;
			end
			idle <= (pend.size() == 0);
		end
	end
endmodule : crsq_core_model

// [test/tb_cipher_regs_and_ram_sequencer.sv]
// ----------------------------------------------------------------------------
// Self-checking bench: register port driven here, cipher cores modelled.
// ----------------------------------------------------------------------------
module tb_cipher_regs_and_ram_sequencer
	import crsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                    clk, sys_rst, we, rreq, rvalid;
	logic [ADDR_W-1:0]       addr;
	logic [DATA_W-1:0]       wval, rval;
	logic [3:0]              lanes;
	logic [KEY_WORDS*32-1:0] ekey, dkey;
	logic                    ekl, dkl, eiv, div, eov, dov, eor, dor;
	logic [BLOCK_W-1:0]      eib, dib, eob, dob;
	logic                    ehold, dhold, eidle, didle;
	logic [31:0]             keys[2][8]; // Key words as written, per direction.
	logic [BLOCK_W-1:0]      blk[8];     // Source blocks of one run.
	int                      fails, total_checks, in_cnt[2];

	// Clock of 40 ns.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	crsq_top #(.DEPTH(128), .FIFO_DEPTH(2)) uut (.clk(clk), .sys_rst(sys_rst),
		.reg_write_strobe(we), .reg_addr_bus(addr), .reg_write_value(wval),
		.reg_byte_lanes(lanes), .reg_read_request(rreq), .read_value_valid(rvalid),
		.reg_read_value(rval), .encrypt_key_value(ekey), .encrypt_key_load(ekl),
		.encrypt_input_block(eib), .encrypt_input_valid(eiv), .encrypt_output_block(eob),
		.encrypt_output_valid(eov), .encrypt_output_ready(eor), .decrypt_key_value(dkey),
		.decrypt_key_load(dkl), .decrypt_input_block(dib), .decrypt_input_valid(div),
		.decrypt_output_block(dob), .decrypt_output_valid(dov), .decrypt_output_ready(dor));
	crsq_core_model enc_core (.clk(clk), .sys_rst(sys_rst), .key_low(ekey[BLOCK_W-1:0]),
		.in_valid(eiv), .in_block(eib), .out_valid(eov), .out_block(eob),
		.out_ready(eor), .hold_off(ehold), .idle(eidle));
	crsq_core_model dec_core (.clk(clk), .sys_rst(sys_rst), .key_low(dkey[BLOCK_W-1:0]),
		.in_valid(div), .in_block(dib), .out_valid(dov), .out_block(dob),
		.out_ready(dor), .hold_off(dhold), .idle(didle));

	// Random core stalls; blocks handed to each core are counted.
	always @(posedge clk) begin
		ehold <= ($urandom_range(0, 2) == 0);
		dhold <= ($urandom_range(0, 2) == 0);
		in_cnt[0] <= in_cnt[0] + int'(eiv === 1'b1);
		in_cnt[1] <= in_cnt[1] + int'(div === 1'b1);
	end

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// One register write; the strobe stands for one edge only.
	task automatic wr(logic [15:0] a, logic [31:0] v, logic [3:0] l = 4'hf);
		@(posedge clk);
		we    <= 1'b1;
		addr  <= a;
		wval  <= v;
		lanes <= l;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr

	// One register read; the answer is due two edges after the request.
	task automatic rd(logic [15:0] a, output logic [31:0] v);
		@(posedge clk);
		rreq <= 1'b1;
		addr <= a;
		@(posedge clk);
		rreq <= 1'b0;
		@(posedge clk);
		check("early valid", rvalid, 32'h0);
		@(posedge clk);
		check("read valid", rvalid, 32'h1);
		v = rval;
	endtask : rd

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : give_verdict

	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict();
	end

	initial begin : main
		logic [31:0] v;
		logic [15:0] src, dst, kb;
		int          n, k;
		{we, rreq, ehold, dhold} = 4'h0;
		addr = 16'h0000;
		wval = 32'h0;
		lanes = 4'hf;
		in_cnt = '{0, 0};
		void'($urandom(97124));
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		rd(16'h0008, v);
		check("count at reset", v, CNT_RST);
		wr(16'h0ffc, 32'h11223344);
		wr(16'h0ffc, 32'haabbccdd, 4'h5);
		rd(16'h0ffc, v);
		check("lane merge", v, 32'h11bb33dd);
		rd(16'h07f0, v);
		check("unmapped read", v, 32'h0);
		wr(16'h0000, 32'h00000015);
		rd(16'h0000, v);
		check("plain pointer", v, 32'h00000015);
		// Keys, highest word first, for both directions.
		for (int m = 0; m < 2; m++) begin
			kb = m ? 16'h0040 : 16'h0020;
			for (int w = 7; w >= 0; w--) begin
				keys[m][w] = $urandom;
				wr(kb + 16'(w * 4), keys[m][w]);
			end
			@(posedge clk);
			check("key load", m ? dkl : ekl, 32'h1);
			@(posedge clk);
			check("key load end", m ? dkl : ekl, 32'h0);
			for (int w = 0; w < 8; w++) begin
				check("key word", m ? dkey[w*32+:32] : ekey[w*32+:32], keys[m][w]);
			end
			rd(kb - 16'(m ? 'h34 : 'h18), v);
			check("setup busy", v, KEY_SETUP_CYCLES - 32'h00000004);
			k = 0;
			do begin
				rd(kb - 16'(m ? 'h34 : 'h18), v);
				k++;
			end while (v !== 32'h0 && k < 8);
			check("setup polls", 32'(k), 32'd3);
		end
		// Block runs: encrypt several blocks, then decrypt a single one.
		for (int dir = 0; dir < 2; dir++) begin
			n = dir ? 1 : $urandom_range(3, 8);
			src = dir ? 16'h1000 : 16'h0800;
			dst = dir ? 16'h0800 : 16'h1000;
			for (int b = 0; b < n; b++) begin
				blk[b] = {$urandom, $urandom, $urandom, $urandom};
				for (int w = 0; w < 4; w++) begin
					wr(src + 16'(b * 16 + w * 4), blk[b][w*32+:32]);
				end
			end
			wr(16'h0000, 32'h0);
			wr(16'h0004, 32'h0);
			wr(dir ? 16'h000c : 16'h0008, 32'(n));
			k = 0;
			while (k < 400 && !(in_cnt[dir] == n && (dir ? didle : eidle))) begin
				@(posedge clk);
				k++;
			end
			repeat (4) @(posedge clk);
			check("blocks fed", 32'(in_cnt[dir]), 32'(n));
			rd(dir ? 16'h000c : 16'h0008, v);
			check("count drained", v, 32'h0);
			rd(dir ? 16'h0004 : 16'h0000, v);
			check("source pointer", v, 32'(n));
			rd(dir ? 16'h0000 : 16'h0004, v);
			check("result pointer", v, 32'(n));
			for (int b = 0; b < n * 4; b++) begin
				rd(dst + 16'(b * 4), v);
				check("result word", v, blk[b/4][(b%4)*32+:32] ^ keys[dir][b%4]);
			end
		end
		give_verdict();
	end
endmodule : tb_cipher_regs_and_ram_sequencer
